// File: hdl/mfc_defs.svh
// Purpose: Constants for the multiframe counter and reference-edge alignment block
// Assumes: 32-bit datapath, four octets per link clock
// Notes:   Definitions only
`ifndef MFC_DEFS_SVH
`define MFC_DEFS_SVH
`define MFC_CNT_W      9
`define MFC_K_MIN      6'h01
`define MFC_K_MAX      6'h20
`define MFC_OCT_MIN    11'h011
`define MFC_OCT_MAX    11'h400
`define MFC_CNT_RST    9'h000
`define MFC_PER_W      16
`define MFC_OCT_PER_LC 2
`endif

// File: hdl/mfc_pkg.sv
// Purpose: Types for the multiframe counter block
// Assumes: Counter width from the defs header
// Notes:   Types only
`include "mfc_defs.svh"
package mfc_pkg;
  typedef logic [`MFC_CNT_W-1:0] mfc_cnt_t;   // Counter value
  typedef logic [`MFC_PER_W-1:0] mfc_per_t;   // Edge spacing
  typedef enum logic [1:0] {MFC_IDLE, MFC_WAIT, MFC_DONE} mfc_align_e;
endpackage : mfc_pkg

// File: hdl/mfc_edge_if.sv
// Purpose: Carries the detected reference edge between modules
// Assumes: Single clock domain
// Notes:   Detector drives, counter consumes
`timescale 1ns/10ps
interface mfc_edge_if;
  logic rise;   // One-cycle pulse on sampled rising edge
  logic level;  // Synchronised reference level
  modport det (output rise, output level);
  modport use_ (input rise, input level);
endinterface : mfc_edge_if

// File: hdl/mfc_edge_det.sv
// Purpose: Two-stage synchroniser and rising edge detector for the reference input
// Assumes: Runs on the link clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module mfc_edge_det (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic sysref,
  mfc_edge_if.det   edge_o
);
  logic meta;   // First synchroniser stage
  logic sync;   // Second synchroniser stage
  logic prev;   // Previous synchronised sample

  // Synchroniser and history, sampled on the link clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= sysref;
      sync <= meta;
      prev <= sync;
    end
  end

  // Zero-to-one change marks a rising edge
  assign edge_o.rise  = sync & ~prev;
  assign edge_o.level = sync;

  a_edge_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    edge_o.rise |=> !edge_o.rise)
    else $error("edge pulse longer than one cycle");
endmodule : mfc_edge_det

// File: hdl/mfc_top.sv
// Purpose: Local multiframe counter re-aligned by reference edges
// Assumes: All inputs synchronous to clk (link clock); F and K held steady
// Notes:   Control bits are plain ports; single-detect clears itself
// Functional notes
// - Counter advances each link clock, period FxK/4
// - Count zero to period minus one, wrap
// - Sample reference on link clock, detect rise
// - Qualifying rising edge forces counter to zero
// - Single-detect aligns once, then self-clears
// - Single-detect holds sync until reference sampled
// - Always-on aligns on every rising edge
// - Always-on checks period, raises interrupt on violation
// - Always-on alone does not hold sync
// - Both bits: realign, hold sync, check period
// - K in 1..32, multiframe 17..1024 octets
// - K times F multiple of four
`timescale 1ns/10ps
`include "mfc_defs.svh"
module mfc_top (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          sysref,
  input  wire logic [7:0]    frm_octets,
  input  wire logic [5:0]    mf_frames,
  input  wire logic          single_set,
  input  wire logic          always_on,
  input  wire logic          viol_clr,
  output      mfc_pkg::mfc_cnt_t lmfc_cnt,
  output      logic          lmfc_wrap,
  output      logic          single_det,
  output      logic          sync_hold,
  output      logic          cfg_err,
  output      logic          period_viol,
  output      logic          irq
);
  import mfc_pkg::*;

  mfc_edge_if edge_i ();   // Edge carrier
  mfc_cnt_t   last_cnt;    // Period minus one
  logic [13:0] oct_mf;     // Octets per multiframe
  logic        align;      // Realign this cycle
  logic        seen;       // A reference edge has been sampled
  mfc_per_t    per_cnt;    // Cycles since last edge
  mfc_per_t    per_exp;    // Multiframe length in cycles
  logic        per_bad;    // Spacing not a multiple of multiframe
  mfc_cnt_t    next_cnt;   // Next counter value

  // Edge detector with synchroniser
  mfc_edge_det u_det (
    .clk    (clk),
    .arst_n (arst_n),
    .sysref (sysref),
    .edge_o (edge_i)
  );

  // Period minus one in link clocks: F*K/4 - 1
  // Operands widened first so the product cannot overflow
  function automatic mfc_cnt_t period_m1(input logic [7:0] f, input logic [5:0] k);
    logic [13:0] p;  // Multiframe length in link clocks
    p = (14'(f) * 14'(k)) >> `MFC_OCT_PER_LC;
    period_m1 = `MFC_CNT_W'(p - 14'h0001);
  endfunction : period_m1

  // Octets per multiframe, for the range checks
  assign oct_mf   = 14'(frm_octets) * 14'(mf_frames);
  // Last count value before the wrap
  assign last_cnt = period_m1(frm_octets, mf_frames);
  // Expected edge spacing in link clocks
  assign per_exp  = `MFC_PER_W'(last_cnt) + 16'h0001;

  // Configuration check on K range, octet range and link-word fit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_err <= 1'b0;
    end else begin
      cfg_err <= (mf_frames < `MFC_K_MIN) || (mf_frames > `MFC_K_MAX)
              || (oct_mf < 14'(`MFC_OCT_MIN)) || (oct_mf > 14'(`MFC_OCT_MAX))
              || (oct_mf[1:0] != 2'h0);
    end
  end

  // Alignment policy: single-detect or always-on
  assign align = edge_i.rise & (single_det | always_on);

  // Counter next value
  always_comb begin
    if (align) begin
      next_cnt = `MFC_CNT_RST;
    end else if (lmfc_cnt >= last_cnt) begin
      next_cnt = `MFC_CNT_RST;
    end else begin
      next_cnt = lmfc_cnt + 9'h001;
    end
  end

  // Multiframe counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lmfc_cnt  <= `MFC_CNT_RST;
      lmfc_wrap <= 1'b0;
    end else begin
      lmfc_cnt  <= next_cnt;
      lmfc_wrap <= (next_cnt == `MFC_CNT_RST);
    end
  end

  // Single-detect bit: set by control, cleared after one edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      single_det <= 1'b0;
    end else if (single_set) begin
      single_det <= 1'b1;
    end else if (edge_i.rise) begin
      single_det <= 1'b0;
    end
  end

  // Records that a reference edge was seen since single-detect armed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen <= 1'b0;
    end else if (single_set) begin
      seen <= 1'b0;
    end else if (edge_i.rise) begin
      seen <= 1'b1;
    end
  end

  // Hold sync only while single-detect waits; always-on alone never holds
  assign sync_hold = single_det & ~seen;

  // Spacing counter between reference edges; saturates so a stopped source never wraps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt <= 16'h0000;
    end else if (edge_i.rise) begin
      per_cnt <= 16'h0001;  // Restart on each edge
    end else begin
      per_cnt <= (per_cnt == 16'hFFFF) ? per_cnt : per_cnt + 16'h0001;  // Count, hold at top
    end
  end

  // Spacing must be a positive multiple of the multiframe length
  assign per_bad = (per_cnt != 16'h0000) && ((per_cnt % per_exp) != 16'h0000);

  // Sticky violation flag, set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_viol <= 1'b0;
    end else if (always_on && edge_i.rise && per_bad) begin
      period_viol <= 1'b1;
    end else if (viol_clr) begin
      period_viol <= 1'b0;
    end
  end

  // Interrupt is the sticky violation flag itself
  assign irq = period_viol;

  // Counter stepping and wrap
  a_wrap_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (!align && lmfc_cnt >= last_cnt) |=> (lmfc_cnt == 9'h000))
    else $error("counter did not wrap to zero");
  a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
    (!align && lmfc_cnt < last_cnt) |=> (lmfc_cnt == $past(lmfc_cnt) + 9'h001))
    else $error("counter did not advance by one");
  a_wrap_flag: assert property (@(posedge clk) disable iff (!arst_n)
    lmfc_wrap |-> (lmfc_cnt == 9'h000))
    else $error("wrap flag high away from zero");

  // Realignment on reference edges
  a_align_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (edge_i.rise && always_on) |=> (lmfc_cnt == 9'h000))
    else $error("always-on edge did not clear counter");
  a_level_align: assert property (@(posedge clk) disable iff (!arst_n)
    (always_on && $rose(edge_i.level)) |=> (lmfc_cnt == 9'h000))
    else $error("synchronised rise did not realign");
  a_no_align: assert property (@(posedge clk) disable iff (!arst_n)
    (edge_i.rise && !always_on && !single_det && lmfc_cnt < last_cnt)
    |=> (lmfc_cnt == $past(lmfc_cnt) + 9'h001))
    else $error("edge realigned with both bits clear");
  a_single_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (edge_i.rise && single_det && !single_set) |=> (!single_det && lmfc_cnt == 9'h000))
    else $error("single-detect did not align and self-clear");
  a_both_bits: assert property (@(posedge clk) disable iff (!arst_n)
    (edge_i.rise && always_on && single_det) |=> (lmfc_cnt == 9'h000))
    else $error("both bits set but no realign");

  // Synchronisation hold
  a_single_arm: assert property (@(posedge clk) disable iff (!arst_n)
    single_set |=> (single_det && sync_hold))
    else $error("single-detect did not arm");
  a_hold_sync: assert property (@(posedge clk) disable iff (!arst_n)
    (single_det && !seen) |-> sync_hold)
    else $error("sync not held while awaiting reference");
  a_hold_keep: assert property (@(posedge clk) disable iff (!arst_n)
    (sync_hold && !edge_i.rise) |=> sync_hold)
    else $error("sync released before reference sampled");
  a_no_hold_on: assert property (@(posedge clk) disable iff (!arst_n)
    (!single_det) |-> !sync_hold)
    else $error("always-on alone held sync");

  // Period check and sticky flag
  a_per_restart: assert property (@(posedge clk) disable iff (!arst_n)
    edge_i.rise |=> (per_cnt == 16'h0001))
    else $error("spacing counter did not restart");
  a_viol_set: assert property (@(posedge clk) disable iff (!arst_n)
    (always_on && edge_i.rise && per_bad) |=> period_viol && irq)
    else $error("period violation not flagged");
  a_viol_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    (period_viol && !viol_clr) |=> period_viol)
    else $error("violation flag dropped without clear");
  a_viol_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (viol_clr && !(always_on && edge_i.rise && per_bad)) |=> (!period_viol && !irq))
    else $error("violation flag not cleared");
endmodule : mfc_top

// File: verif/mfc_ref_src.sv
// Purpose: Reference pulse source standing in for the clock chip
// Assumes: Period in link clocks is set by the bench
// Notes:   Output stays low while stopped
`timescale 1ns/10ps
module mfc_ref_src (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] per,
  output      logic        sysref
);
  logic [15:0] ph;  // Phase within one period

  initial sysref = 1'b0;
  // Square wave, first rise one edge after run goes high
  // Launched from the link clock alone; no device clock capture needed
  always @(posedge clk) begin
    if (!run) begin
      ph     <= 16'h0000;
      sysref <= 1'b0;
    end else begin
      ph     <= (ph >= per - 16'h0001) ? 16'h0000 : ph + 16'h0001;
      sysref <= (ph < (per >> 1));
    end
  end
endmodule : mfc_ref_src

// File: verif/tb_mfc_top.sv
// Purpose: Self-checking bench for the multiframe counter
// Assumes: One link clock; reference pulses from the source model
// Notes:   Realign is judged by counter phase seven edges after a zero
`timescale 1ns/10ps
module tb_mfc_top;
  import mfc_pkg::*;
  logic        clk, arst_n, single_set, always_on, viol_clr, run;  // Bench drives
  logic [7:0]  frm_octets;
  logic [5:0]  mf_frames;
  logic [15:0] per;
  logic        sysref, lmfc_wrap, single_det, sync_hold, cfg_err, period_viol, irq;
  mfc_cnt_t    lmfc_cnt;
  int          fails = 0, n_compared = 0, cyc = 0;

  mfc_top dut (.clk(clk), .arst_n(arst_n), .sysref(sysref), .frm_octets(frm_octets),
    .mf_frames(mf_frames), .single_set(single_set), .always_on(always_on),
    .viol_clr(viol_clr), .lmfc_cnt(lmfc_cnt), .lmfc_wrap(lmfc_wrap),
    .single_det(single_det), .sync_hold(sync_hold), .cfg_err(cfg_err),
    .period_viol(period_viol), .irq(irq));
  mfc_ref_src src (.clk(clk), .run(run), .per(per), .sysref(sysref));

  task automatic end_of_test;
    $display("Compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic do_reset(input logic [7:0] f, input logic [5:0] k);
    @(posedge clk);
    arst_n     <= 1'b0;
    frm_octets <= f;
    mf_frames  <= k;
    run        <= 1'b0;
    always_on  <= 1'b0;
    per        <= 16'd1000;
    tick(2);
    @(posedge clk) arst_n <= 1'b1;
    tick(3);
  endtask : do_reset

  task automatic wait_cnt(input mfc_cnt_t v);
    for (int i = 0; i < 300 && lmfc_cnt !== v; i++) tick(1);
  endtask : wait_cnt

  // One reference rise two edges after a counter zero; natural phase would be 7
  task automatic pulse_at(input logic al);
    wait_cnt(9'h000);
    @(posedge clk) run <= 1'b1;
    tick(6);
    chk((lmfc_cnt === 9'h001 || lmfc_cnt === 9'h002) === al, "realign");
    @(posedge clk) run <= 1'b0;
    tick(4);
  endtask : pulse_at

  task automatic arm;
    @(posedge clk) single_set <= 1'b1;
    @(posedge clk) single_set <= 1'b0;
    tick(1);
  endtask : arm

  task automatic t_count;
    logic [7:0] f [8] = '{8'h02, 8'h20, 8'h01, 8'h03, 8'h01, 8'h04, 8'h03, 8'h04};
    logic [5:0] k [8] = '{6'h10, 6'h20, 6'h20, 6'h20, 6'h10, 6'h21, 6'h07, 6'h00};
    int         p [8] = '{8, 256, 8, 24, 0, 0, 0, 0};
    int         n;
    for (int i = 0; i < 8; i++) begin
      do_reset(f[i], k[i]);
      chk(cfg_err === (p[i] == 0), "config check");
      if (p[i] != 0) begin
        wait_cnt(mfc_cnt_t'(p[i] - 1));
        tick(1);
        chk(lmfc_cnt === 9'h000, "wrap to zero");
        n = 0;
        repeat (4 * p[i]) begin
          tick(1);
          n += int'(lmfc_wrap === 1'b1);
        end
        chk(n == 4 && lmfc_cnt === 9'h000, "period");
      end
    end
  endtask : t_count

  task automatic t_align;
    do_reset(8'h02, 6'h10);
    pulse_at(1'b0);
    arm();
    chk(single_det === 1'b1 && sync_hold === 1'b1, "single armed");
    pulse_at(1'b1);
    chk(single_det === 1'b0 && sync_hold === 1'b0, "single done");
    pulse_at(1'b0);
    @(posedge clk) always_on <= 1'b1;
    tick(1);
    chk(sync_hold === 1'b0, "always no hold");
    pulse_at(1'b1);
    pulse_at(1'b1);
    arm();
    chk(sync_hold === 1'b1, "both hold");
    pulse_at(1'b1);
    chk(sync_hold === 1'b0, "both released");
  endtask : t_align

  task automatic t_period;
    do_reset(8'h02, 6'h10);
    @(posedge clk) per <= 16'd16;
    always_on <= 1'b1;
    run <= 1'b1;
    tick(40);
    @(posedge clk) viol_clr <= 1'b1;
    @(posedge clk) viol_clr <= 1'b0;
    tick(80);
    chk(period_viol === 1'b0 && irq === 1'b0, "good period");
    @(posedge clk) per <= 16'd17;
    tick(60);
    @(posedge clk) run <= 1'b0;
    tick(20);
    chk(period_viol === 1'b1 && irq === 1'b1, "bad period");
    @(posedge clk) viol_clr <= 1'b1;
    @(posedge clk) viol_clr <= 1'b0;
    tick(2);
    chk(period_viol === 1'b0 && irq === 1'b0, "cleared");
  endtask : t_period

  // Single link clock for the whole run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    {arst_n, single_set, always_on, viol_clr, run} = 5'h00;
    frm_octets = 8'h02;
    mf_frames  = 6'h10;
    per        = 16'd1000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_count();
    t_align();
    t_period();
    end_of_test();
  end
endmodule : tb_mfc_top
